// ### hdl/timer16_pkg.sv
// Shared constants and types for the 16-bit timer core and its bus controller.
package timer16_pkg;

   // ---------------------------------------------------------------
   // Byte-wide I/O map of the timer
   // ---------------------------------------------------------------
   localparam int unsigned IO_ADDR_W  = 6;
   localparam logic [5:0]  IO_CNT_L   = 6'h00;
   localparam logic [5:0]  IO_CNT_H   = 6'h01;
   localparam logic [5:0]  IO_CMPA_L  = 6'h02;
   localparam logic [5:0]  IO_CMPA_H  = 6'h03;
   localparam logic [5:0]  IO_CMPB_L  = 6'h04;
   localparam logic [5:0]  IO_CMPB_H  = 6'h05;
   localparam logic [5:0]  IO_CAP_L   = 6'h06;
   localparam logic [5:0]  IO_CAP_H   = 6'h07;
   localparam logic [5:0]  IO_CTRL_A  = 6'h08;
   localparam logic [5:0]  IO_CTRL_B  = 6'h09;
   localparam logic [5:0]  IO_FLAGS   = 6'h0a;
   localparam logic [5:0]  IO_IRQ_EN  = 6'h0b;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned CB_NOISE_BIT  = 7;
   localparam int unsigned CB_EDGE_BIT   = 6;
   localparam int unsigned CB_WGM_LSB    = 3;
   localparam int unsigned CA_WGM_LSB    = 0;
   localparam int unsigned FLAG_OVF_BIT  = 0;
   localparam int unsigned FLAG_CAP_BIT  = 1;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [15:0] WORD_RESET    = 16'h0000;

   // ---------------------------------------------------------------
   // Counter limits and modes
   // ---------------------------------------------------------------
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [15:0] TOP_8BIT   = 16'h00ff;
   localparam logic [15:0] TOP_9BIT   = 16'h01ff;
   localparam logic [15:0] TOP_10BIT  = 16'h03ff;
   localparam int unsigned FILTER_SAMPLES = 4;
   localparam int unsigned PRESC_W        = 10;

   typedef enum logic [2:0] {
      CS_STOP     = 3'h0,
      CS_DIV1     = 3'h1,
      CS_DIV8     = 3'h2,
      CS_DIV64    = 3'h3,
      CS_DIV256   = 3'h4,
      CS_DIV1024  = 3'h5,
      CS_EXT_FALL = 3'h6,
      CS_EXT_RISE = 3'h7
   } clock_source_t;

   // ---------------------------------------------------------------
   // Controller registers on AXI4-Lite
   // ---------------------------------------------------------------
   localparam logic [7:0]  AXI_IO_WRITE  = 8'h00;
   localparam logic [7:0]  AXI_IO_READ   = 8'h04;
   localparam logic [7:0]  AXI_RESULT    = 8'h08;
   localparam logic [7:0]  AXI_IRQ       = 8'h0c;
   localparam logic [7:0]  AXI_ACK       = 8'h10;
   localparam int unsigned HOST_ADDR_LSB = 8;
   localparam int unsigned BUSY_BIT      = 8;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ### hdl/timer16_io_if.sv
// Byte-wide I/O bus between the CPU-side controller and the timer core.
`timescale 1ns/1ps
interface timer16_io_if;
   logic [5:0] io_addr;
   logic       io_wr;
   logic       io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic       io_rvalid;
   logic       irq_overflow;
   logic       irq_capture;
   logic       ack_overflow;
   logic       ack_capture;

   modport device (
      input  io_addr, io_wr, io_rd, io_wdata, ack_overflow, ack_capture,
      output io_rdata, io_rvalid, irq_overflow, irq_capture
   );
   modport cpu (
      output io_addr, io_wr, io_rd, io_wdata, ack_overflow, ack_capture,
      input  io_rdata, io_rvalid, irq_overflow, irq_capture
   );
endinterface

// ### hdl/timer16_core.sv
// Sixteen-bit timer core: byte access, counter unit and input capture unit.
`timescale 1ns/1ps

module timer16_core (
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  arst_n,
   // CPU side
   timer16_io_if.device bus,
   // Pins
   input  wire logic  capture_input_pin,
   input  wire logic  comparator_output,
   input  wire logic  comparator_select,
   input  wire logic  external_tick_pin,
   // Status
   output logic [15:0] timer_count,
   output logic        counting_down
);

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cap;
      logic [15:0] cmpa;
      logic [15:0] cmpb;
      logic [7:0]  temp;
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [7:0]  ien;
      logic [7:0]  rdata;
      logic [1:0]  flags;
      logic        down;
      logic [9:0]  presc;
      logic [1:0]  ext_s;
      logic        ext_prev;
      logic [1:0]  pin_s;
      logic [1:0]  cmp_s;
      logic [3:0]  filt;
      logic        filt_out;
      logic        det_prev;
      logic        rvalid;
      logic        irq_ovf;
      logic        irq_cap;
   } core_state_t;

   core_state_t q;
   core_state_t d;

   // ---------------------------------------------------------------
   // Mode decoding
   // ---------------------------------------------------------------
   function automatic logic [15:0] top_of(input logic [3:0] wgm, input logic [15:0] cmpa,
                                          input logic [15:0] cap);
      case (wgm)
         4'h1, 4'h5:             top_of = timer16_pkg::TOP_8BIT;
         4'h2, 4'h6:             top_of = timer16_pkg::TOP_9BIT;
         4'h3, 4'h7:             top_of = timer16_pkg::TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf: top_of = cmpa;
         4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
         default:                top_of = timer16_pkg::CNT_MAX;
      endcase
   endfunction

   // Modes whose top is held in the capture register.
   function automatic logic cap_is_top(input logic [3:0] wgm);
      cap_is_top = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);
   endfunction

   function automatic logic dual_slope(input logic [3:0] wgm);
      dual_slope = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction

   function automatic logic fast_pwm(input logic [3:0] wgm);
      fast_pwm = (wgm inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
   endfunction

   // A prescaler tap fires when all bits below the division point are ones.
   function automatic logic presc_tap(input logic [9:0] presc, input logic [9:0] mask);
      presc_tap = ((presc & mask) == mask);
   endfunction

   logic [3:0]  wgm;
   logic [15:0] top;
   logic        tick;
   logic        ext_edge;
   logic        src;
   logic        det_in;
   logic        cap_edge;
   logic        set_ovf;
   logic        set_cap;
   logic [1:0]  clr_flags;
   logic [15:0] wr_word;

   always_comb begin
      d         = q;
      wgm       = {q.ctrl_b[timer16_pkg::CB_WGM_LSB +: 2], q.ctrl_a[timer16_pkg::CA_WGM_LSB +: 2]};
      top       = top_of(wgm, q.cmpa, q.cap);
      set_ovf   = 1'b0;
      set_cap   = 1'b0;
      clr_flags = 2'h0;
      wr_word   = {q.temp, bus.io_wdata};

      // ------------------------------------------------------------
      // Tick selection
      // ------------------------------------------------------------
      d.presc    = q.presc + 10'h001;
      d.ext_s    = {q.ext_s[0], external_tick_pin};
      d.ext_prev = q.ext_s[1];
      ext_edge   = 1'b0;
      case (timer16_pkg::clock_source_t'(q.ctrl_b[2:0]))
         timer16_pkg::CS_STOP:     tick = 1'b0;
         timer16_pkg::CS_DIV1:     tick = 1'b1;
         timer16_pkg::CS_DIV8:     tick = presc_tap(q.presc, 10'h007);
         timer16_pkg::CS_DIV64:    tick = presc_tap(q.presc, 10'h03f);
         timer16_pkg::CS_DIV256:   tick = presc_tap(q.presc, 10'h0ff);
         timer16_pkg::CS_DIV1024:  tick = presc_tap(q.presc, 10'h3ff);
         timer16_pkg::CS_EXT_FALL: begin
            ext_edge = q.ext_prev & ~q.ext_s[1];
            tick     = ext_edge;
         end
         timer16_pkg::CS_EXT_RISE: begin
            ext_edge = ~q.ext_prev & q.ext_s[1];
            tick     = ext_edge;
         end
         default:                  tick = 1'b0;
      endcase

      // ------------------------------------------------------------
      // Counter unit
      // ------------------------------------------------------------
      if (tick) begin
         if (dual_slope(wgm)) begin
            if (!q.down) begin
               if (q.cnt >= top && top != timer16_pkg::CNT_BOTTOM) begin
                  d.down = 1'b1;
                  d.cnt  = q.cnt - 16'h0001;
               end else begin
                  d.cnt = q.cnt + 16'h0001;
               end
            end else if (q.cnt == timer16_pkg::CNT_BOTTOM) begin
               d.down  = 1'b0;
               d.cnt   = q.cnt + 16'h0001;
               set_ovf = 1'b1;
            end else begin
               d.cnt = q.cnt - 16'h0001;
            end
         end else begin
            d.down = 1'b0;
            // Clear at top; normal and the compare-top and capture-top clear modes flag the wrap at max.
            if (q.cnt == top) begin
               d.cnt = timer16_pkg::CNT_BOTTOM;
            end else begin
               d.cnt = q.cnt + 16'h0001;
            end
            if (fast_pwm(wgm)) begin
               set_ovf = (q.cnt == top);
            end else begin
               set_ovf = (q.cnt == timer16_pkg::CNT_MAX);
            end
         end
      end

      // ------------------------------------------------------------
      // Input capture unit
      // ------------------------------------------------------------
      // Both sources are synchronised before the select, so switching sources can
      // itself look like an edge; software clears the flag after a change.
      d.pin_s = {q.pin_s[0], capture_input_pin};
      d.cmp_s = {q.cmp_s[0], comparator_output};
      src     = comparator_select ? q.cmp_s[1] : q.pin_s[1];
      d.filt  = {q.filt[2:0], src};
      if (q.filt == 4'hf) begin
         d.filt_out = 1'b1;
      end else if (q.filt == 4'h0) begin
         d.filt_out = 1'b0;
      end
      det_in     = q.ctrl_b[timer16_pkg::CB_NOISE_BIT] ? q.filt_out : src;
      d.det_prev = det_in;
      cap_edge   = q.ctrl_b[timer16_pkg::CB_EDGE_BIT] ? (det_in & ~q.det_prev) : (~det_in & q.det_prev);
      if (cap_edge && !cap_is_top(wgm)) begin
         d.cap   = q.cnt;
         set_cap = 1'b1;
      end

      // ------------------------------------------------------------
      // CPU byte access
      // ------------------------------------------------------------
      d.rvalid = bus.io_rd;
      d.rdata  = timer16_pkg::BYTE_RESET;
      if (bus.io_rd) begin
         case (bus.io_addr)
            timer16_pkg::IO_CNT_L:  begin
               d.rdata = q.cnt[7:0];
               d.temp  = q.cnt[15:8];
            end
            timer16_pkg::IO_CAP_L:  begin
               d.rdata = q.cap[7:0];
               d.temp  = q.cap[15:8];
            end
            timer16_pkg::IO_CNT_H,
            timer16_pkg::IO_CAP_H:  d.rdata = q.temp;
            timer16_pkg::IO_CMPA_L: d.rdata = q.cmpa[7:0];
            timer16_pkg::IO_CMPA_H: d.rdata = q.cmpa[15:8];
            timer16_pkg::IO_CMPB_L: d.rdata = q.cmpb[7:0];
            timer16_pkg::IO_CMPB_H: d.rdata = q.cmpb[15:8];
            timer16_pkg::IO_CTRL_A: d.rdata = q.ctrl_a;
            timer16_pkg::IO_CTRL_B: d.rdata = q.ctrl_b;
            timer16_pkg::IO_FLAGS:  d.rdata = {6'h00, q.flags};
            timer16_pkg::IO_IRQ_EN: d.rdata = q.ien;
            default:                d.rdata = timer16_pkg::BYTE_RESET;
         endcase
      end
      if (bus.io_wr) begin
         case (bus.io_addr)
            timer16_pkg::IO_CNT_H,
            timer16_pkg::IO_CMPA_H,
            timer16_pkg::IO_CMPB_H,
            timer16_pkg::IO_CAP_H:  d.temp = bus.io_wdata;
            // The latch is left alone on low-byte writes so one high byte can serve many.
            timer16_pkg::IO_CNT_L:  begin
               d.cnt = wr_word;
            end
            timer16_pkg::IO_CMPA_L: d.cmpa = wr_word;
            timer16_pkg::IO_CMPB_L: d.cmpb = wr_word;
            timer16_pkg::IO_CAP_L:  begin
               if (cap_is_top(wgm)) begin
                  d.cap = wr_word;
               end
            end
            timer16_pkg::IO_CTRL_A: d.ctrl_a = bus.io_wdata;
            timer16_pkg::IO_CTRL_B: d.ctrl_b = bus.io_wdata;
            timer16_pkg::IO_FLAGS:  clr_flags = bus.io_wdata[1:0];
            timer16_pkg::IO_IRQ_EN: d.ien = bus.io_wdata;
            default:                d.temp = q.temp;
         endcase
      end

      // ------------------------------------------------------------
      // Flags and interrupt requests
      // ------------------------------------------------------------
      clr_flags[timer16_pkg::FLAG_OVF_BIT] = clr_flags[timer16_pkg::FLAG_OVF_BIT] | bus.ack_overflow;
      clr_flags[timer16_pkg::FLAG_CAP_BIT] = clr_flags[timer16_pkg::FLAG_CAP_BIT] | bus.ack_capture;
      // A new event in the clearing cycle survives the clear.
      d.flags = (q.flags & ~clr_flags) | {set_cap, set_ovf};
      d.irq_ovf = d.flags[timer16_pkg::FLAG_OVF_BIT] & d.ien[timer16_pkg::FLAG_OVF_BIT];
      d.irq_cap = d.flags[timer16_pkg::FLAG_CAP_BIT] & d.ien[timer16_pkg::FLAG_CAP_BIT];
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign bus.io_rdata     = q.rdata;
   assign bus.io_rvalid    = q.rvalid;
   assign bus.irq_overflow = q.irq_ovf;
   assign bus.irq_capture  = q.irq_cap;
   assign timer_count      = q.cnt;
   assign counting_down    = q.down;

endmodule

// ### hdl/timer16_cpu_port.sv
// CPU-side controller: AXI4-Lite registers turned into byte accesses of the timer.
`timescale 1ns/1ps
module timer16_cpu_port (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         arst_n,
   // AXI4-Lite write
   input  wire logic [31:0]  awaddr,
   input  wire logic         awvalid,
   output logic              awready,
   input  wire logic [31:0]  wdata,
   input  wire logic [3:0]   wstrb,
   input  wire logic         wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire logic         bready,
   // AXI4-Lite read
   input  wire logic [31:0]  araddr,
   input  wire logic         arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire logic         rready,
   // Timer side
   timer16_io_if.cpu         bus
);

   typedef struct packed {
      logic        aw_have;
      logic        w_have;
      logic [7:0]  aw;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [5:0]  io_addr;
      logic        io_wr;
      logic        io_rd;
      logic [7:0]  io_wdata;
      logic        busy;
      logic [7:0]  result;
      logic        ack_ovf;
      logic        ack_cap;
   } port_state_t;

   port_state_t q;
   port_state_t d;

   always_comb begin
      d         = q;
      d.io_wr   = 1'b0;
      d.io_rd   = 1'b0;
      d.ack_ovf = 1'b0;
      d.ack_cap = 1'b0;

      // ------------------------------------------------------------
      // Write path: address and data in either order, one at a time
      // ------------------------------------------------------------
      if (awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.aw      = awaddr[7:0];
      end
      if (wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wd     = wdata;
         d.ws     = wstrb;
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = timer16_pkg::RESP_OKAY;
         // Byte accesses go out one per request, so software sets the byte order.
         case (q.aw)
            timer16_pkg::AXI_IO_WRITE: begin
               d.io_wr    = q.ws[0];
               d.io_addr  = q.wd[timer16_pkg::HOST_ADDR_LSB +: 6];
               d.io_wdata = q.wd[7:0];
            end
            timer16_pkg::AXI_IO_READ:  begin
               d.io_rd   = 1'b1;
               d.io_addr = q.wd[timer16_pkg::HOST_ADDR_LSB +: 6];
               d.busy    = 1'b1;
            end
            timer16_pkg::AXI_ACK:      begin
               d.ack_ovf = q.wd[0];
               d.ack_cap = q.wd[1];
            end
            default:                   d.bresp = timer16_pkg::RESP_SLVERR;
         endcase
      end
      d.awready = !d.aw_have && !d.bvalid;
      d.wready  = !d.w_have && !d.bvalid;

      if (bus.io_rvalid) begin
         d.result = bus.io_rdata;
         d.busy   = 1'b0;
      end

      // ------------------------------------------------------------
      // Read path
      // ------------------------------------------------------------
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = timer16_pkg::RESP_OKAY;
         case (araddr[7:0])
            timer16_pkg::AXI_RESULT: d.rdata = {23'h000000, q.busy, q.result};
            timer16_pkg::AXI_IRQ:    d.rdata = {30'h00000000, bus.irq_capture, bus.irq_overflow};
            default:                 begin
               d.rdata = 32'h00000000;
               d.rresp = timer16_pkg::RESP_SLVERR;
            end
         endcase
      end
      d.arready = !d.rvalid;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign awready          = q.awready;
   assign wready           = q.wready;
   assign bvalid           = q.bvalid;
   assign bresp            = q.bresp;
   assign arready          = q.arready;
   assign rvalid           = q.rvalid;
   assign rresp            = q.rresp;
   assign rdata            = q.rdata;
   assign bus.io_addr      = q.io_addr;
   assign bus.io_wr        = q.io_wr;
   assign bus.io_rd        = q.io_rd;
   assign bus.io_wdata     = q.io_wdata;
   assign bus.ack_overflow = q.ack_ovf;
   assign bus.ack_capture  = q.ack_cap;

endmodule

// ### verif/timer16_checker.sv
// Checks on the byte bus that joins the timer core to its controller.
`timescale 1ns/1ps
module timer16_checker (
   // Clock and reset
   input wire logic       clock,
   input wire logic       arst_n,
   // Byte bus
   input wire logic [5:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       io_rvalid,
   input wire logic       irq_overflow,
   input wire logic       irq_capture,
   input wire logic       ack_overflow,
   input wire logic       ack_capture
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [7:0] hi_q;
   logic       known_q;
   // A low read of counter or capture loads a byte we cannot see, so the model forgets it.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hi_q <= 8'h00;
         known_q <= 1'b1;
      end else if (io_wr && io_addr[0] && io_addr < 6'h08) begin
         hi_q <= io_wdata;
         known_q <= 1'b1;
      end else if (io_rd && (io_addr == 6'h00 || io_addr == 6'h06)) begin
         known_q <= 1'b0;
      end
   end
   property p_rd_answer; io_rd |=> io_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_no_stray; io_rvalid |-> $past(io_rd); endproperty
   a_no_stray: assert property (p_no_stray) else $error("answer without read");
   property p_idle_zero; !io_rvalid |-> io_rdata == 8'h00; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read byte not zero when idle");
   property p_latch_read;
      io_rd && known_q && (io_addr == 6'h01 || io_addr == 6'h07) |=> io_rdata == $past(hi_q);
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("high read not from latch");
   property p_unmapped; io_rd && io_addr > 6'h0b |=> io_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_one_op; !(io_wr && io_rd); endproperty
   a_one_op: assert property (p_one_op) else $error("write and read together");
   property p_wr_pulse; io_wr |=> !io_wr; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
   property p_ack_cap; ack_capture |=> !irq_capture; endproperty
   a_ack_cap: assert property (p_ack_cap) else $error("capture request not cleared");
   property p_ack_ovf; ack_overflow |=> !irq_overflow; endproperty
   a_ack_ovf: assert property (p_ack_ovf) else $error("overflow request not cleared");
   c_hi_read: cover property (io_rd && io_addr == 6'h01 ##1 io_rvalid);
   c_ack_cap: cover property (irq_capture ##1 ack_capture);
   c_ack_ovf: cover property (irq_overflow ##1 ack_overflow);
endmodule

// ### verif/timer16_access_counter_capture_test.sv
// Bench for the timer core joined to its AXI4-Lite controller.
`timescale 1ns/1ps
module timer16_access_counter_capture_test;
   logic        clock = 1'b0, arst_n = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, seed = 32'd67489;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, counting_down;
   logic [1:0]  bresp, rresp;
   logic        cap_pin = 1'b0, cmp_out = 1'b0, cmp_sel = 1'b0;
   logic [15:0] timer_count, t;
   logic [33:0] exp_q[$];
   int          n_mismatch = 0, checks = 0, cyc = 0;
   timer16_io_if io ();
   timer16_cpu_port u_timer16_cpu_port (.clock(clock), .arst_n(arst_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .bus(io));
   timer16_core u_timer16_core (.clock(clock), .arst_n(arst_n), .bus(io), .capture_input_pin(cap_pin),
      .comparator_output(cmp_out), .comparator_select(cmp_sel), .external_tick_pin(1'b0),
      .timer_count(timer_count), .counting_down(counting_down));
   timer16_checker u_timer16_checker (.clock(clock), .arst_n(arst_n), .io_addr(io.io_addr),
      .io_wr(io.io_wr), .io_rd(io.io_rd), .io_wdata(io.io_wdata), .io_rdata(io.io_rdata),
      .io_rvalid(io.io_rvalid), .irq_overflow(io.irq_overflow), .irq_capture(io.irq_capture),
      .ack_overflow(io.ack_overflow), .ack_capture(io.ack_capture));
   initial forever #50 clock = ~clock;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic cmp_bus(input string what, input logic [33:0] e, input logic [33:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic cmp_cnt(input string what, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clock) begin
      if (bvalid && bready) cmp_bus("bresp", exp_q.pop_front(), {bresp, 32'h0});
      if (rvalid && rready) cmp_bus("rdata", exp_q.pop_front(), {rresp, rdata});
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clock);
      exp_q.push_back({r, 32'h0});
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge clock);
      exp_q.push_back(e);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic io_wr(input logic [5:0] a, input logic [7:0] b);
      axi_wr(timer16_pkg::AXI_IO_WRITE, {18'h0, a, b}, timer16_pkg::RESP_OKAY);
   endtask
   task automatic io_rd(input logic [5:0] a, input logic [7:0] e);
      axi_wr(timer16_pkg::AXI_IO_READ, {18'h0, a, 8'h00}, timer16_pkg::RESP_OKAY);
      repeat (3) @(posedge clock);
      axi_rd(timer16_pkg::AXI_RESULT, {timer16_pkg::RESP_OKAY, 24'h0, e});
   endtask
   task automatic w16(input logic [5:0] a, input logic [15:0] v);
      io_wr(a + 6'h01, v[15:8]);
      io_wr(a, v[7:0]);
   endtask
   task automatic r16(input logic [5:0] a, input logic [15:0] v);
      io_rd(a, v[7:0]);
      io_rd(a + 6'h01, v[15:8]);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      r16(timer16_pkg::IO_CAP_L, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         w16(timer16_pkg::IO_CNT_L, seed[15:0]);
         r16(timer16_pkg::IO_CNT_L, seed[15:0]);
         cmp_cnt("count", seed[15:0], timer_count);
      end
      io_wr(timer16_pkg::IO_CMPA_H, 8'h5a);
      io_wr(timer16_pkg::IO_CMPA_L, 8'h01);
      io_wr(timer16_pkg::IO_CMPB_L, 8'h02);
      io_rd(timer16_pkg::IO_CAP_H, 8'h5a);
      io_rd(timer16_pkg::IO_CNT_L, seed[7:0]);
      r16(timer16_pkg::IO_CMPA_L, 16'h5a01);
      r16(timer16_pkg::IO_CMPB_L, 16'h5a02);
      io_rd(timer16_pkg::IO_CNT_H, seed[15:8]);
      io_rd(6'h3f, 8'h00);
      axi_wr(8'h14, 32'h0, timer16_pkg::RESP_SLVERR);
      $display("test byte access done");
      w16(timer16_pkg::IO_CNT_L, 16'hfff0);
      io_wr(timer16_pkg::IO_IRQ_EN, 8'h03);
      io_wr(timer16_pkg::IO_CTRL_B, 8'h01);
      @(negedge clock) t = timer_count;
      repeat (10) @(negedge clock);
      cmp_cnt("step", t + 16'd10, timer_count);
      repeat (20) @(posedge clock);
      axi_rd(timer16_pkg::AXI_IRQ, {timer16_pkg::RESP_OKAY, 32'h1});
      axi_wr(timer16_pkg::AXI_ACK, 32'h1, timer16_pkg::RESP_OKAY);
      axi_rd(timer16_pkg::AXI_IRQ, {timer16_pkg::RESP_OKAY, 32'h0});
      io_wr(timer16_pkg::IO_CTRL_B, 8'h00);
      @(negedge clock) t = timer_count;
      repeat (10) @(negedge clock);
      cmp_cnt("stop", t, timer_count);
      w16(timer16_pkg::IO_CNT_L, 16'h01ff);
      io_wr(timer16_pkg::IO_CTRL_A, 8'h02);
      io_wr(timer16_pkg::IO_CTRL_B, 8'h01);
      repeat (2) @(negedge clock);
      cmp_cnt("down", 16'h0001, {15'h0, counting_down});
      $display("test counting done");
      // Cases: pin rising, pin falling, comparator rising.
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         io_wr(timer16_pkg::IO_CTRL_B, (k == 1) ? 8'h00 : 8'h40);
         cmp_sel <= (k == 2);
         w16(timer16_pkg::IO_CNT_L, seed[15:0]);
         io_wr(timer16_pkg::IO_FLAGS, 8'h02);
         if (k == 2) cmp_out <= 1'b1;
         else cap_pin <= (k == 0);
         repeat (8) @(posedge clock);
         axi_rd(timer16_pkg::AXI_IRQ, {timer16_pkg::RESP_OKAY, 32'h2});
         r16(timer16_pkg::IO_CAP_L, seed[15:0]);
         axi_wr(timer16_pkg::AXI_ACK, 32'h2, timer16_pkg::RESP_OKAY);
      end
      axi_rd(timer16_pkg::AXI_IRQ, {timer16_pkg::RESP_OKAY, 32'h0});
      w16(timer16_pkg::IO_CAP_L, 16'h7788);
      r16(timer16_pkg::IO_CAP_L, seed[15:0]);
      io_wr(timer16_pkg::IO_CTRL_B, 8'h18);
      w16(timer16_pkg::IO_CAP_L, 16'h7788);
      r16(timer16_pkg::IO_CAP_L, 16'h7788);
      cmp_out <= 1'b0;
      repeat (8) @(posedge clock);
      io_rd(timer16_pkg::IO_FLAGS, 8'h00);
      $display("test capture done");
      test_done();
   end
endmodule
